// File: core/async_serial_port.sv
// Purpose: Full duplex async serial port with 8/9-bit frames and baud timer
// Assumes: Register port and timer controls are on mclk; pins are async
// Notes:   Writes to the data location go to transmit, reads return receive
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Data location writes load transmit holding register; transmit never readable.
// - Data location reads return buffered receive register.
// - Done flags are cleared only by software writes.
// - Transmit uses baud timer low byte; receive uses hidden copy, same reload.
// - Baud ticks on every second overflow; overflow each 256 minus reload clocks.
// - Start edge forces receive timer reload immediately.
// - Timer clock from system, /4, /12, /48, external /8 or pin.
// - Control bit 7 selects 8-bit (0) or 9-bit (1) frames.
// - 8-bit frame: low start, eight data LSB first, stop; ten bits.
// - Writing the transmit register starts transmission.
// - Transmit-done flag sets when stop-bit period begins.
// - Receiver works only while receive enable bit is one.
// - 8-bit receive loads byte, stop to ninth bit, if flag clear and address ok.
// - Failed load leaves buffer, ninth bit and receive-done flag unchanged.
// - On overrun buffer keeps first byte; later frame is lost.
// - 9-bit frame adds ninth bit from control bit 3 before stop.
// - 9-bit receive stores ninth bit, ignores stop; address filter uses ninth bit.
// - Interrupt requested when enabled and either done flag is set.
module async_serial_port
  import serial_port_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset,
  // Register port
  input  wire logic       regSel,
  input  wire logic       regWr,
  input  wire logic [7:0] regWrData,
  output logic      [7:0] regRdData,
  // Baud timer controls
  input  wire logic       timerRun,
  input  wire logic [7:0] baudTimerReload,
  input  wire clk_src_t   clkSrcSel,
  input  wire logic       extOscClk,
  input  wire logic       timerPin,
  // Interrupt
  input  wire logic       serialIntEnable,
  output logic            serialIntReq,
  // Serial pins
  input  wire logic       serialRxPin,
  output logic            serialTxPin
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, first stage read only by the second
  logic [1:0] rxSync_q;
  logic [1:0] extSync_q;
  logic [1:0] pinSync_q;
  logic       rxPrev_q;
  logic       extPrev_q;
  logic       pinPrev_q;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxSync_q  <= 2'h3;
      extSync_q <= 2'h0;
      pinSync_q <= 2'h0;
      rxPrev_q  <= 1'b1;
      extPrev_q <= 1'b0;
      pinPrev_q <= 1'b0;
    end else begin
      rxSync_q  <= {rxSync_q[0], serialRxPin};
      extSync_q <= {extSync_q[0], extOscClk};
      pinSync_q <= {pinSync_q[0], timerPin};
      rxPrev_q  <= rxSync_q[1];
      extPrev_q <= extSync_q[1];
      pinPrev_q <= pinSync_q[1];
    end
  end

  wire logic rxLine   = rxSync_q[1];
  wire logic extRise  = extSync_q[1] & ~extPrev_q;
  wire logic pinRise  = pinSync_q[1] & ~pinPrev_q;
  wire logic rxFall   = rxPrev_q & ~rxLine;

  ////////////////////////////////////////////////////////////////////////////
  // Timer clock prescaler; slow external edges limit the pin source rate
  logic [5:0] preCnt_q;
  logic [5:0] preCnt_d;
  logic [2:0] extCnt_q;
  logic [5:0] preLast;
  logic       preWrap;
  logic       timerTick;
  assign preLast  = (clkSrcSel == SRC_DIV4)  ? DIV4_LAST :
                    (clkSrcSel == SRC_DIV12) ? DIV12_LAST : DIV48_LAST;
  assign preWrap  = (preCnt_q >= preLast);
  assign preCnt_d = preWrap ? 6'h00 : preCnt_q + 6'h01;
  // Six-way source choice
  always_comb begin
    case (clkSrcSel)
      SRC_SYS:   timerTick = 1'b1;
      SRC_DIV4,
      SRC_DIV12,
      SRC_DIV48: timerTick = preWrap;
      SRC_EXT8:  timerTick = extRise && (extCnt_q == EXT_DIV_LAST);
      SRC_PIN:   timerTick = pinRise;
      default:   timerTick = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      preCnt_q <= 6'h00;
      extCnt_q <= 3'h0;
    end else begin
      preCnt_q <= preCnt_d;
      if (extRise)
        extCnt_q <= extCnt_q + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit timer and receive copy, both halved to give baud ticks
  ctrl_t      ctrl_q;
  logic [7:0] baudTimerLow_q;
  logic [7:0] rxTimer_q;
  logic       txHalf_q;
  logic       rxHalf_q;
  rx_state_t  rxState_q;
  logic       rxStartSeen;
  logic       txOvf;
  logic       rxOvf;
  logic       txTick;
  logic       rxTick;
  assign rxStartSeen = (rxState_q == RX_IDLE) && ctrl_q.receiveEnableBit && rxFall;
  assign txOvf  = timerRun && timerTick && (baudTimerLow_q == TMR_TOP);
  assign rxOvf  = timerRun && timerTick && (rxTimer_q == TMR_TOP);
  assign txTick = txOvf && txHalf_q;
  // First receive overflow after a start edge lands mid-bit
  assign rxTick = rxOvf && !rxHalf_q && (rxState_q != RX_IDLE);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      baudTimerLow_q <= 8'h00;
      rxTimer_q      <= 8'h00;
      txHalf_q       <= 1'b0;
      rxHalf_q       <= 1'b0;
    end else begin
      if (txOvf)
        baudTimerLow_q <= baudTimerReload;
      else if (timerRun && timerTick)
        baudTimerLow_q <= baudTimerLow_q + 8'h01;
      if (txOvf)
        txHalf_q <= ~txHalf_q;
      if (rxStartSeen) begin
        rxTimer_q <= baudTimerReload;
        rxHalf_q  <= 1'b0;
      end else begin
        if (rxOvf)
          rxTimer_q <= baudTimerReload;
        else if (timerRun && timerTick)
          rxTimer_q <= rxTimer_q + 8'h01;
        if (rxOvf)
          rxHalf_q <= ~rxHalf_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port decode
  logic [7:0] rxBuf_q;
  logic       ctrlWr;
  logic       dataWr;

  assign ctrlWr = regWr && (regSel == SEL_CONTROL);
  assign dataWr = regWr && (regSel == SEL_DATA);
  // Reads have no side effects, so the mux is simply registered
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      regRdData <= 8'h00;
    else
      regRdData <= (regSel == SEL_DATA) ? rxBuf_q : ctrl_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: frame shifted out LSB first, idle line high
  logic [10:0] txShift_q;
  logic [3:0]  txLeft_q;
  logic        txSetDone;
  logic        txNinth;
  // 8-bit frames put a stop in the ninth slot, so both lengths share a shifter
  assign txNinth   = ctrl_q.frameFormatSelect ? ctrl_q.ninthTxBit : 1'b1;
  assign txSetDone = txTick && (txLeft_q == 4'h1);
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      txShift_q   <= 11'h7ff;
      txLeft_q    <= 4'h0;
      serialTxPin <= 1'b1;
    end else if (dataWr) begin
      // A write always starts a fresh frame, even mid-frame
      txShift_q <= {1'b1, txNinth, regWrData, 1'b0};
      txLeft_q  <= ctrl_q.frameFormatSelect ? LEN_9BIT : LEN_8BIT;
    end else if (txTick && (txLeft_q != 4'h0)) begin
      serialTxPin <= txShift_q[0];
      txShift_q   <= {1'b1, txShift_q[10:1]};
      txLeft_q    <= txLeft_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: sample on receive ticks, decide load at the stop bit
  logic [7:0] rxData_q;
  logic       rxNinthBit_q;
  logic [3:0] rxCnt_q;
  logic       rxNinthVal;
  logic       rxLoadOk;
  logic       rxLoad;
  logic       rxLastData;
  assign rxLastData = ctrl_q.frameFormatSelect ? (rxCnt_q == DATA_BITS)
                                               : (rxCnt_q == DATA_BITS - 4'h1);
  assign rxNinthVal = ctrl_q.frameFormatSelect ? rxNinthBit_q : rxLine;
  assign rxLoadOk   = !ctrl_q.rxDoneFlag && (!ctrl_q.multiprocEnable || rxNinthVal);
  assign rxLoad     = rxTick && (rxState_q == RX_STOP) && rxLoadOk;
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      rxState_q    <= RX_IDLE;
      rxData_q     <= 8'h00;
      rxNinthBit_q <= 1'b0;
      rxCnt_q      <= 4'h0;
    end else if (!ctrl_q.receiveEnableBit) begin
      rxState_q <= RX_IDLE;
    end else begin
      case (rxState_q)
        RX_IDLE: begin
          if (rxStartSeen)
            rxState_q <= RX_START;
        end
        RX_START: begin
          if (rxTick) begin
            rxCnt_q   <= 4'h0;
            rxState_q <= rxLine ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rxTick) begin
            if (rxCnt_q < DATA_BITS)
              rxData_q <= {rxLine, rxData_q[7:1]};
            else
              rxNinthBit_q <= rxLine;
            rxCnt_q <= rxCnt_q + 4'h1;
            if (rxLastData)
              rxState_q <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rxTick)
            rxState_q <= RX_IDLE;
        end
        default: rxState_q <= RX_IDLE;
      endcase
    end
  end

  // Receive buffer changes only on a qualified load
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      rxBuf_q <= 8'h00;
    else if (rxLoad)
      rxBuf_q <= rxData_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; hardware set beats a same-cycle software clear
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctrl_q <= CTRL_RESET;
    end else begin
      if (ctrlWr)
        ctrl_q <= {regWrData[7], 1'b1, regWrData[5:0]};
      if (txSetDone)
        ctrl_q.txDoneFlag <= 1'b1;
      if (rxLoad) begin
        ctrl_q.rxDoneFlag <= 1'b1;
        ctrl_q.ninthRxBit <= rxNinthVal;
      end
    end
  end

  // Interrupt request follows the flags; nothing here clears them
  always_ff @(posedge mclk or posedge reset) begin
    if (reset)
      serialIntReq <= 1'b0;
    else
      serialIntReq <= serialIntEnable && (ctrl_q.txDoneFlag || ctrl_q.rxDoneFlag);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_stopSample;
    rxTick && (rxState_q == RX_STOP);
  endsequence
  property p_wrLoadsTx;
    @(posedge mclk) disable iff (reset) dataWr |=> (txLeft_q >= LEN_8BIT) && !txShift_q[0];
  endproperty
  a_wrLoadsTx: assert property (p_wrLoadsTx) else $error("write did not start a frame");
  property p_rdBuf;
    @(posedge mclk) disable iff (reset) (regSel == SEL_DATA) |=> regRdData == $past(rxBuf_q);
  endproperty
  a_rdBuf: assert property (p_rdBuf) else $error("data read not from receive buffer");
  property p_flagHold;
    @(posedge mclk) disable iff (reset) ctrl_q.txDoneFlag && !ctrlWr |=> ctrl_q.txDoneFlag;
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("done flag cleared by hardware");
  property p_rxReload;
    @(posedge mclk) disable iff (reset) rxStartSeen |=> rxTimer_q == $past(baudTimerReload);
  endproperty
  a_rxReload: assert property (p_rxReload) else $error("start edge did not reload timer");
  property p_txHalf;
    @(posedge mclk) disable iff (reset) txOvf && !txHalf_q |-> !txTick ##1 txHalf_q;
  endproperty
  a_txHalf: assert property (p_txHalf) else $error("tick not on every second overflow");
  property p_txDoneAtStop;
    @(posedge mclk) disable iff (reset) txSetDone && !dataWr |=> ctrl_q.txDoneFlag && serialTxPin;
  endproperty
  a_txDoneAtStop: assert property (p_txDoneAtStop) else $error("done not at stop bit");
  property p_rxDisabled;
    @(posedge mclk) disable iff (reset) !ctrl_q.receiveEnableBit |=> rxState_q == RX_IDLE;
  endproperty
  a_rxDisabled: assert property (p_rxDisabled) else $error("receiver ran while disabled");
  property p_overrun;
    @(posedge mclk) disable iff (reset) s_stopSample and ctrl_q.rxDoneFlag |=> $stable(rxBuf_q);
  endproperty
  a_overrun: assert property (p_overrun) else $error("buffer overwritten on overrun");
  property p_glitch;
    @(posedge mclk) disable iff (reset)
      rxTick && (rxState_q == RX_START) && rxLine && ctrl_q.receiveEnableBit |=> rxState_q == RX_IDLE;
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch start not abandoned");
  property p_intReq;
    @(posedge mclk) disable iff (reset) serialIntEnable && ctrl_q.rxDoneFlag |=> serialIntReq;
  endproperty
  a_intReq: assert property (p_intReq) else $error("interrupt not requested");

endmodule : async_serial_port
`default_nettype wire

// File: inc/serial_port_pkg.sv
// Purpose: Shared constants and types for the async serial port
// Assumes: One system clock, register side strobes on the same clock
// Notes:   Control bit positions follow the serial_port_control layout
`default_nettype none
package serial_port_pkg;

  // Register select codes on the register port
  localparam logic       SEL_CONTROL = 1'b0;
  localparam logic       SEL_DATA    = 1'b1;

  // Control register reset value, bit 6 is unused and reads one
  localparam logic [7:0] CTRL_RESET  = 8'h40;

  // Timer overflow wrap point and prescaler divides
  localparam logic [7:0] TMR_TOP     = 8'hff;
  localparam logic [5:0] DIV4_LAST   = 6'h03;
  localparam logic [5:0] DIV12_LAST  = 6'h0b;
  localparam logic [5:0] DIV48_LAST  = 6'h2f;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;

  // Frame lengths including start and stop bits, and data bits per frame
  localparam logic [3:0] LEN_8BIT    = 4'ha;
  localparam logic [3:0] LEN_9BIT    = 4'hb;
  localparam logic [3:0] DATA_BITS   = 4'h8;

  // Baud timer clock sources
  typedef enum logic [2:0] {
    SRC_SYS    = 3'b000,
    SRC_DIV4   = 3'b001,
    SRC_DIV12  = 3'b010,
    SRC_DIV48  = 3'b011,
    SRC_EXT8   = 3'b100,
    SRC_PIN    = 3'b101
  } clk_src_t;

  // Receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } rx_state_t;

  // serial_port_control fields, bit 7 down to bit 0
  typedef struct packed {
    logic frameFormatSelect;
    logic unusedOne;
    logic multiprocEnable;
    logic receiveEnableBit;
    logic ninthTxBit;
    logic ninthRxBit;
    logic txDoneFlag;
    logic rxDoneFlag;
  } ctrl_t;

endpackage : serial_port_pkg
`default_nettype wire

// File: verif/serial_peer_model.sv
// Purpose: Remote async serial transceiver facing the port's pins
// Assumes: Bit time in ns is set by the bench to match the baud timer
// Notes:   Line idles high; the decoder samples each bit at mid-bit
`timescale 1ns/1ps
`default_nettype none
module serial_peer_model (
  // Setup
  input  wire logic       serialTxPin,
  input  wire logic       nineMode,
  input  var  int         bitNs,
  // Line and decoded frame
  output logic            serialRxPin,
  output logic      [7:0] gotByte,
  output logic            gotNinth,
  output logic            gotStop,
  output int              gotCount
);
  ////////////////////////////////////////////////////////////////////
  // One frame: start, data LSB first, ninth in nine-bit mode, stop
  task automatic sendFrame(input logic [7:0] d, input logic ninth, input logic stop);
    int k;
    serialRxPin = 1'b0;
    #(bitNs);
    for (k = 0; k < 8; k++) begin
      serialRxPin = d[k];
      #(bitNs);
    end
    if (nineMode) begin
      serialRxPin = ninth;
      #(bitNs);
    end
    serialRxPin = stop;
    #(bitNs);
    serialRxPin = 1'b1;
    #(bitNs);
  endtask : sendFrame

  // Short low pulse, too brief to survive the mid-bit start check
  task automatic glitchLow(input int ns);
    serialRxPin = 1'b0;
    #(ns);
    serialRxPin = 1'b1;
  endtask : glitchLow

  ////////////////////////////////////////////////////////////////////
  // Decoder: a falling edge starts a frame, sample 1.5 bits later
  initial begin : decode
    int k;
    serialRxPin = 1'b1;
    gotCount = 0;
    gotByte = 8'h00;
    gotNinth = 1'b0;
    gotStop = 1'b0;
    forever begin
      @(negedge serialTxPin);
      #(bitNs * 3 / 2);
      for (k = 0; k < 8; k++) begin
        gotByte[k] = serialTxPin;
        #(bitNs);
      end
      if (nineMode) begin
        gotNinth = serialTxPin;
        #(bitNs);
      end
      gotStop = serialTxPin;
      gotCount++;
    end
  end
endmodule : serial_peer_model
`default_nettype wire

// File: verif/tb_async_serial_port.sv
// Purpose: Self-checking bench for the async serial port
// Assumes: Reload 0xfc, so one bit is 8 timer ticks
// Notes:   Register reads have one cycle of latency
`timescale 1ns/1ps
`default_nettype none
module tb_async_serial_port;
  import serial_port_pkg::*;
  logic       mclk, reset, regSel, regWr, timerRun, extOscClk, timerPin;
  logic       serialIntEnable, serialIntReq, serialRxPin, serialTxPin;
  logic       nineMode, peerNinth, peerStop;
  logic [7:0] regWrData, regRdData, baudTimerReload, peerByte;
  clk_src_t   clkSrcSel;
  int         bitNs, peerCount, error_cnt, comparisons, i;
  clk_src_t   srcTab[6] = '{SRC_SYS, SRC_DIV4, SRC_DIV12, SRC_DIV48, SRC_EXT8, SRC_PIN};
  int         nsTab[6] = '{800, 3200, 9600, 38400, 25600, 3200};

  async_serial_port async_serial_port_inst (.mclk(mclk), .reset(reset), .regSel(regSel),
    .regWr(regWr), .regWrData(regWrData), .regRdData(regRdData), .timerRun(timerRun),
    .baudTimerReload(baudTimerReload), .clkSrcSel(clkSrcSel), .extOscClk(extOscClk),
    .timerPin(timerPin), .serialIntEnable(serialIntEnable), .serialIntReq(serialIntReq),
    .serialRxPin(serialRxPin), .serialTxPin(serialTxPin));
  serial_peer_model serial_peer_model_inst (.serialTxPin(serialTxPin), .nineMode(nineMode),
    .bitNs(bitNs), .serialRxPin(serialRxPin), .gotByte(peerByte), .gotNinth(peerNinth),
    .gotStop(peerStop), .gotCount(peerCount));

  ////////////////////////////////////////////////////////////////////
  // System clock, and slower free clocks for the external sources
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // Free clocks move one step after mclk so every rising edge is seen alike
  initial begin
    extOscClk = 1'b0;
    timerPin = 1'b0;
    forever begin
      repeat (2) @(posedge mclk);
      #1;
      extOscClk = ~extOscClk;
      timerPin = ~timerPin;
    end
  end

  ////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Strobe lasts one edge; released after it so calls may follow
  task automatic writeReg(input logic sel, input logic [7:0] d);
    @(posedge mclk);
    #1;
    regSel = sel;
    regWr = 1'b1;
    regWrData = d;
    @(posedge mclk);
    #1;
    regWr = 1'b0;
  endtask : writeReg

  task automatic checkReg(input logic sel, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    regSel = sel;
    @(posedge mclk);
    #1;
    check(regRdData, exp);
  endtask : checkReg

  // Bounded wait for the peer to decode frame number n
  task automatic waitPeer(input int n);
    int k;
    for (k = 0; k < bitNs / 5 + 200 && peerCount != n; k++) @(posedge mclk);
    if (peerCount != n) begin
      error_cnt++;
      $display("timeout at %0t waiting for frame %0d", $time, n);
      final_report();
    end
  endtask : waitPeer

  initial begin
    #5000000;
    error_cnt++;
    $display("timeout at %0t", $time);
    final_report();
  end

  ////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    reset = 1'b1;
    regSel = 1'b0;
    regWr = 1'b0;
    regWrData = 8'h00;
    timerRun = 1'b1;
    baudTimerReload = 8'hfc;
    clkSrcSel = SRC_SYS;
    serialIntEnable = 1'b1;
    nineMode = 1'b0;
    bitNs = 800;
    error_cnt = 0;
    comparisons = 0;
    repeat (4) @(posedge mclk);
    #1;
    reset = 1'b0;
    checkReg(SEL_CONTROL, CTRL_RESET);
    checkReg(SEL_DATA, 8'h00);
    $display("test reset done");
    // Transmit once from every timer source
    for (i = 0; i < 6; i++) begin
      clkSrcSel = srcTab[i];
      bitNs = nsTab[i];
      writeReg(SEL_CONTROL, 8'h10);
      writeReg(SEL_DATA, 8'ha5 ^ 8'(i));
      waitPeer(i + 1);
      check(peerByte, 8'ha5 ^ 8'(i));
      check({7'h0, peerStop}, 8'h01);
      checkReg(SEL_CONTROL, 8'h52);
      check({7'h0, serialIntReq}, 8'h01);
      checkReg(SEL_DATA, 8'h00);
    end
    clkSrcSel = SRC_SYS;
    bitNs = 800;
    writeReg(SEL_CONTROL, 8'h10);
    checkReg(SEL_CONTROL, 8'h50);
    check({7'h0, serialIntReq}, 8'h00);
    $display("test transmit done");
    // Receive, overrun, address filter, disabled receiver, glitch
    serial_peer_model_inst.sendFrame(8'h3c, 1'b0, 1'b1);
    checkReg(SEL_DATA, 8'h3c);
    checkReg(SEL_CONTROL, 8'h55);
    serial_peer_model_inst.sendFrame(8'h77, 1'b0, 1'b1);
    checkReg(SEL_DATA, 8'h3c);
    writeReg(SEL_CONTROL, 8'h30);
    serial_peer_model_inst.sendFrame(8'h66, 1'b0, 1'b0);
    checkReg(SEL_CONTROL, 8'h70);
    checkReg(SEL_DATA, 8'h3c);
    writeReg(SEL_CONTROL, 8'h00);
    serial_peer_model_inst.sendFrame(8'h11, 1'b0, 1'b1);
    checkReg(SEL_DATA, 8'h3c);
    checkReg(SEL_CONTROL, 8'h40);
    writeReg(SEL_CONTROL, 8'h10);
    serial_peer_model_inst.glitchLow(250);
    // Long enough for a wrongly accepted frame to finish and set its flag
    repeat (100) @(posedge mclk);
    checkReg(SEL_CONTROL, 8'h50);
    $display("test receive done");
    // Nine-bit frames both ways
    nineMode = 1'b1;
    writeReg(SEL_CONTROL, 8'hb8);
    writeReg(SEL_DATA, 8'h96);
    waitPeer(7);
    check(peerByte, 8'h96);
    check({7'h0, peerNinth}, 8'h01);
    check({7'h0, peerStop}, 8'h01);
    writeReg(SEL_CONTROL, 8'hb8);
    serial_peer_model_inst.sendFrame(8'h5a, 1'b0, 1'b1);
    checkReg(SEL_CONTROL, 8'hf8);
    serial_peer_model_inst.sendFrame(8'hc3, 1'b1, 1'b0);
    checkReg(SEL_DATA, 8'hc3);
    checkReg(SEL_CONTROL, 8'hfd);
    // Receive-done flag still set, so only the enable can drop the request
    serialIntEnable = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    check({7'h0, serialIntReq}, 8'h00);
    $display("test nine-bit done");
    final_report();
  end
endmodule : tb_async_serial_port
`default_nettype wire
